/* File: hw/ptmr_period_timer.sv */
// Purpose: Eight-bit period timer with prescaler, postscaler and interrupt
// Assumes: clk is the instruction clock; bus inputs synchronous to clk
// Notes:   Read data valid in the cycle after the read strobe
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

module ptmr_period_timer
	import ptmr_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	// Register port
	input  wire ptmr_pkg::ptmr_bus_req_t bus_req,
	output      logic [7:0]            rdata,
	// Serial port shift clock source
	output      logic                  ssp_shift_tick,
	// PWM time base
	output      ptmr_pkg::ptmr_tbase_t pwm_tbase,
	// Interrupt
	output      logic                  irq
);
	import ptmr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [3:0] pre_tc(input logic [1:0] sel);
		unique case (sel)
			2'b00: pre_tc = PRE_TC_1;
			2'b01: pre_tc = PRE_TC_4;
			default: pre_tc = PRE_TC_16;
		endcase
	endfunction

	function automatic logic hit(input ptmr_bus_req_t r, input logic [7:0] off);
		hit = r.wr && (r.addr == off);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	ptmr_state_t st_reg;
	ptmr_state_t st_next;

	logic        tick;
	logic        is_match;
	logic        post_done;
	logic [7:0]  rd_mux;

	always_comb begin
		st_next = st_reg;
		st_next.match = 1'b0;
		tick = 1'b0;
		is_match = 1'b0;
		post_done = 1'b0;
		rd_mux = 8'h00;

		// Prescaler and counter
		if (st_reg.ctrl[BIT_RUN]) begin
			if (st_reg.pre >= pre_tc(st_reg.ctrl[POS_PRE +: 2])) begin
				st_next.pre = RST_PRE;
				tick = 1'b1;
			end else begin
				st_next.pre = st_reg.pre + 4'h1;
			end
		end
		if (tick) begin
			is_match = (st_reg.count == st_reg.period);
			if (is_match) begin
				st_next.count = RST_COUNT;
			end else begin
				st_next.count = st_reg.count + 8'h01;
			end
		end
		st_next.match = is_match;

		// Postscaler
		if (is_match) begin
			if (st_reg.post == st_reg.ctrl[POS_POST +: 4]) begin
				st_next.post = RST_POST;
				post_done = 1'b1;
			end else begin
				st_next.post = st_reg.post + 4'h1;
			end
		end

		// Register writes
		if (hit(bus_req, OFF_COUNT)) begin
			st_next.count = bus_req.wdata;
			st_next.pre = RST_PRE;
			st_next.post = RST_POST;
		end
		if (hit(bus_req, OFF_CTRL)) begin
			st_next.ctrl = bus_req.wdata[6:0];
			st_next.pre = RST_PRE;
			st_next.post = RST_POST;
		end
		if (hit(bus_req, OFF_PERIOD)) begin
			st_next.period = bus_req.wdata;
		end
		if (hit(bus_req, OFF_ENABLES)) begin
			st_next.ie = bus_req.wdata[BIT_MATCH_IE];
		end
		if (hit(bus_req, OFF_INTCTL) || hit(bus_req, OFF_INTCTL_ALIAS)) begin
			st_next.global_irq_enable = bus_req.wdata[BIT_GIE];
			st_next.peripheral_irq_enable = bus_req.wdata[BIT_PERIPHERAL_IRQ_ENABLE];
		end
		// Flag: write one to clear, set wins
		if (hit(bus_req, OFF_FLAGS) && bus_req.wdata[BIT_MATCH_FLAG]) begin
			st_next.flag = 1'b0;
		end
		if (post_done) begin
			st_next.flag = 1'b1;
		end

		// Read mux
		unique case (bus_req.addr)
			OFF_COUNT:   rd_mux = st_reg.count;
			OFF_CTRL:    rd_mux = {1'b0, st_reg.ctrl};
			OFF_PERIOD:  rd_mux = st_reg.period;
			OFF_FLAGS:   rd_mux = 8'({st_reg.flag, 1'b0});
			OFF_ENABLES: rd_mux = 8'({st_reg.ie, 1'b0});
			OFF_INTCTL, OFF_INTCTL_ALIAS:
				rd_mux = {st_reg.global_irq_enable, st_reg.peripheral_irq_enable, 6'h00};
			default:     rd_mux = 8'h00;
		endcase
		st_next.rdata = bus_req.rd ? rd_mux : 8'h00;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg.count <= RST_COUNT;
			st_reg.period <= RST_PERIOD;
			st_reg.ctrl <= RST_CTRL;
			st_reg.pre <= RST_PRE;
			st_reg.post <= RST_POST;
			st_reg.flag <= 1'b0;
			st_reg.ie <= 1'b0;
			st_reg.global_irq_enable <= 1'b0;
			st_reg.peripheral_irq_enable <= 1'b0;
			st_reg.match <= 1'b0;
			st_reg.rdata <= 8'h00;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign rdata = st_reg.rdata;
	assign ssp_shift_tick = st_reg.match;
	assign pwm_tbase.count = st_reg.count;
	assign pwm_tbase.match = st_reg.match;
	assign irq = st_reg.flag && st_reg.ie && st_reg.peripheral_irq_enable && st_reg.global_irq_enable;

endmodule

/* File: hw/ptmr_pkg.sv */
// Purpose: Shared constants and types for the period timer
// Assumes: 8-bit register port, one clock
// Notes:   Offsets are the register addresses of the block
package ptmr_pkg;

	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 8;

	// Register offsets
	localparam logic [7:0]  OFF_INTCTL       = 8'h0b;
	localparam logic [7:0]  OFF_INTCTL_ALIAS = 8'h8b;
	localparam logic [7:0]  OFF_FLAGS        = 8'h0c;
	localparam logic [7:0]  OFF_COUNT        = 8'h11;
	localparam logic [7:0]  OFF_CTRL         = 8'h12;
	localparam logic [7:0]  OFF_ENABLES      = 8'h8c;
	localparam logic [7:0]  OFF_PERIOD       = 8'h92;

	// Reset values
	localparam logic [7:0]  RST_COUNT        = 8'h00;
	localparam logic [7:0]  RST_PERIOD       = 8'hff;
	localparam logic [6:0]  RST_CTRL         = 7'h00;
	localparam logic [3:0]  RST_PRE          = 4'h0;
	localparam logic [3:0]  RST_POST         = 4'h0;

	// Field positions
	localparam int          BIT_MATCH_FLAG   = 1;
	localparam int          BIT_MATCH_IE     = 1;
	localparam int          BIT_GIE          = 7;
	localparam int          BIT_PERIPHERAL_IRQ_ENABLE         = 6;
	localparam int          BIT_RUN          = 2;
	localparam int          POS_PRE          = 0;
	localparam int          POS_POST         = 3;

	// Prescale terminal counts (divide by 1, 4, 16)
	localparam logic [3:0]  PRE_TC_1         = 4'h0;
	localparam logic [3:0]  PRE_TC_4         = 4'h3;
	localparam logic [3:0]  PRE_TC_16        = 4'hf;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} ptmr_bus_req_t;

	typedef struct packed {
		logic [7:0] count;
		logic       match;
	} ptmr_tbase_t;

	typedef struct packed {
		logic [7:0] count;
		logic [7:0] period;
		logic [6:0] ctrl;
		logic [3:0] pre;
		logic [3:0] post;
		logic       flag;
		logic       ie;
		logic       global_irq_enable;
		logic       peripheral_irq_enable;
		logic       match;
		logic [7:0] rdata;
	} ptmr_state_t;

endpackage

/* File: tb/ptmr_period_timer_properties.sv */
// Purpose: Port checks
// Assumes: Top ports only
// Notes:   Bound below
`timescale 1ns/1ps
module ptmr_period_timer_properties
	import ptmr_pkg::*;
(
	// Ports watched
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire ptmr_pkg::ptmr_bus_req_t bus_req,
	input wire logic [7:0]            rdata,
	input wire logic                  ssp_shift_tick,
	input wire ptmr_pkg::ptmr_tbase_t pwm_tbase,
	input wire logic                  irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_SAME: assert property (ssp_shift_tick == pwm_tbase.match) else $error("same");
	AST_ZERO: assert property (ssp_shift_tick && !$past(bus_req.wr)
		|-> pwm_tbase.count == 8'h00) else $error("zero");
	AST_WRAP: assert property (pwm_tbase.count == 8'h00 && $past(pwm_tbase.count) != 8'h00
		&& !$past(bus_req.wr) |-> ssp_shift_tick) else $error("wrap");
	AST_IDLE: assert property (!$past(bus_req.rd) |-> rdata == 8'h00) else $error("idle");
	AST_B7: assert property ($past(bus_req.rd && bus_req.addr == OFF_CTRL)
		|-> !rdata[7]) else $error("b7");
	AST_CRD: assert property ($past(bus_req.rd && bus_req.addr == OFF_COUNT)
		|-> rdata == $past(pwm_tbase.count)) else $error("crd");
	AST_CWR: assert property ($past(bus_req.wr && bus_req.addr == OFF_COUNT)
		|-> pwm_tbase.count == $past(bus_req.wdata)) else $error("cwr");
	AST_IRQ: assert property ($past(bus_req.rd && bus_req.addr == OFF_FLAGS && irq)
		|-> rdata[1]) else $error("irq");
endmodule
bind ptmr_period_timer ptmr_period_timer_properties u_chk (.clk(clk), .rst_b(rst_b),
	.bus_req(bus_req), .rdata(rdata), .ssp_shift_tick(ssp_shift_tick),
	.pwm_tbase(pwm_tbase), .irq(irq));

/* File: tb/ptmr_partner.sv */
// Purpose: Serial port and PWM side
// Assumes: One clock
// Notes:   Counts match pulses
`timescale 1ns/1ps
module ptmr_partner
	import ptmr_pkg::*;
(
	// Timer side
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire logic                  tick,
	input wire ptmr_pkg::ptmr_tbase_t tbase,
	// Match total
	output int                        edges
);
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			edges <= 0;
		else if (tick && tbase.match)
			edges <= edges + 1;
endmodule

/* File: tb/ptmr_period_timer_tb.sv */
// Purpose: Bench
// Assumes: Design and partner
// Notes:   Seeded random cases
`timescale 1ns/1ps
module ptmr_period_timer_tb;
	import ptmr_pkg::*;
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end
	logic          clk, rst_b, irq, tick;
	logic [7:0]    rdata;
	ptmr_bus_req_t b;
	ptmr_tbase_t   t;
	int            err_total, n_checks, cyc, edges, c, d, pre, post, per;
	ptmr_period_timer dut (.clk(clk), .rst_b(rst_b), .bus_req(b), .rdata(rdata),
		.ssp_shift_tick(tick), .pwm_tbase(t), .irq(irq));
	ptmr_partner u_far (.clk(clk), .rst_b(rst_b), .tick(tick), .tbase(t), .edges(edges));
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		b <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		b.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string s);
		@(posedge clk);
		b <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		b.rd <= 1'b0;
		#1 `CHK(s, e, rdata)
	endtask
	task automatic tk();
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (!tick && c < 5000);
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		rst_b = 0;
		b = '0;
		void'($urandom(32'hfe28));
		repeat (6) @(posedge clk);
		rst_b <= 1;
		rd(OFF_PERIOD, 8'hff, "per");
		rd(OFF_COUNT, 8'h00, "cnt");
		rd(8'h00, 8'h00, "gap");
		wr(OFF_COUNT, 8'h5a);
		wr(OFF_CTRL, 8'hfb);
		rd(OFF_CTRL, 8'h7b, "ctl");
		rd(OFF_COUNT, 8'h5a, "keep");
		wr(OFF_INTCTL, 8'hc0);
		wr(OFF_ENABLES, 8'h02);
		repeat (6) begin
			pre = $urandom % 4;
			post = $urandom % 16;
			per = $urandom % 8 + 1;
			d = pre == 0 ? 1 : pre == 1 ? 4 : 16;
			wr(OFF_CTRL, 8'h00);
			wr(OFF_FLAGS, 8'h02);
			wr(OFF_COUNT, 8'h00);
			wr(OFF_PERIOD, per[7:0]);
			rd(OFF_PERIOD, per[7:0], "pw");
			c = edges;
			wr(OFF_CTRL, {1'b0, post[3:0], 1'b1, pre[1:0]});
			do begin
				@(posedge clk);
				#1;
			end while (!irq && cyc < 89000);
			@(posedge clk);
			#1;
			`CHK("post", post + 1, edges - c)
			tk();
			tk();
			`CHK("gap", d * (per + 1), c)
			wr(OFF_ENABLES, 8'h00);
			#1 `CHK("mask", 1'b0, irq)
			rd(OFF_FLAGS, 8'h02, "flag");
			wr(OFF_ENABLES, 8'h02);
		end
		wr(OFF_CTRL, 8'h00);
		wr(OFF_FLAGS, 8'h02);
		rd(OFF_FLAGS, 8'h00, "clr");
		summarize();
	end
endmodule
